// file: rtl/fopc_bus_eng.sv
// Flash pin engine: one asynchronous write or read cycle per request
`timescale 1ns/100ps
module fopc_bus_eng
	import fopc_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 24,
	parameter int DIV = fopc_pkg::PHASE_CYC
) (
	input wire logic clk_i, // System clock
	input wire logic rstn_i, // Async reset, active low
	fopc_bus_if.eng bus, // Request channel
	output logic [2:0] cs_o, // Chip selects
	output logic oe_n_o, // Output enable, active low
	output logic we_n_o, // Write enable, active low
	output logic [AW-1:0] addr_o, // Flash address
	output logic [DW-1:0] dq_o, // Data out
	output logic dq_oe_n_o, // Data drive enable, low drives
	input wire logic [DW-1:0] dq_i // Data in
);
	typedef enum logic [1:0] {E_IDLE, E_SET, E_STROBE, E_HOLD} fopc_eng_e;

	fopc_eng_e st_r;
	logic [CNT_W-1:0] div_r;
	logic wr_r;
	logic done_r;
	logic [DW-1:0] rdata_r;
	wire tick = (div_r == CNT_W'(DIV - 1));

	assign bus.done = done_r;
	assign bus.rdata = rdata_r;

	// ----------------------------------------------------------------
	// Phase divider: one enable pulse per phase
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_r <= '0;
		end else if (st_r == E_IDLE || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= E_IDLE;
			cs_o <= CS_OFF;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			addr_o <= '0;
			dq_o <= '0;
			dq_oe_n_o <= 1'b1;
			wr_r <= 1'b0;
			done_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			done_r <= 1'b0;
			unique case (st_r)
				E_IDLE: if (bus.req) begin
					addr_o <= bus.addr;
					dq_o <= bus.wdata;
					wr_r <= bus.wr;
					dq_oe_n_o <= !bus.wr;
					cs_o <= CS_ON;
					st_r <= E_SET;
				end
				E_SET: if (tick) begin
					we_n_o <= !wr_r; // R16
					oe_n_o <= wr_r;
					st_r <= E_STROBE;
				end
				E_STROBE: if (tick) begin
					we_n_o <= 1'b1;
					oe_n_o <= 1'b1;
					if (!wr_r) begin
						rdata_r <= dq_i;
					end
					st_r <= E_HOLD;
				end
				E_HOLD: if (tick) begin
					// Deselect after every cycle so each read refreshes status
					cs_o <= CS_OFF; // R3
					dq_oe_n_o <= 1'b1;
					done_r <= 1'b1;
					st_r <= E_IDLE;
				end
			endcase
		end
	end
endmodule

// file: rtl/fopc_bus_if.sv
// Bus-cycle request channel between the sequencer and the pin engine
`timescale 1ns/100ps
interface fopc_bus_if #(
	parameter int DW = 16,
	parameter int AW = 24
);
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	logic done;

	modport ctl(output req, output wr, output addr, output wdata, input rdata, input done);
	modport eng(input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

// file: rtl/fopc_ctrl.sv
// Host-side protection-register program controller for a parallel flash
//
// Overview of operation
// R1: Program is setup code then data write
// R2: Device errors on out-of-space protection address
// R3: Poll ready bit; CE/OE toggle refreshes status
// R4: Decode lock/supply/program bits into result
// R5: Supply error blocks programs until cleared
// R6: Error bits persist until clear-status command
// R7: Write read-array code after last program
// R8: Completion pin low while operation runs
// R9: Completion pin floats in suspend and reset
// R10: Reset mid-operation: wait pulse plus recovery
// R11: Interrupted operations are reissued by software
// R12: Reset or power-off clears device status
// R13: Command latch holds the last written command
// R14: Latch returns to read-array after reset
// R15: Issue read-array before reading the array
// R16: Writes only with write enable and select
// R17: Reset low disables the device entirely
// R18: Low program supply inhibits data changes
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
module fopc_ctrl
	import fopc_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 24,
	parameter int RST_PULSE = fopc_pkg::RST_PULSE_CYC,
	parameter int RST_RECOV = fopc_pkg::RST_RECOV_CYC
) (
	input wire logic clk_i, // System clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic [7:0] addr_i, // Register byte address
	input wire logic [31:0] wdata_i, // Register write data
	input wire logic we_i, // Register write strobe
	input wire logic re_i, // Register read strobe
	output logic [31:0] rdata_o, // Read data, cycle after strobe
	output logic irq_o, // Level interrupt
	output logic [2:0] chip_select_o, // Flash chip selects
	output logic flash_oe_n_o, // Flash output enable, active low
	output logic flash_we_n_o, // Flash write enable, active low
	output logic [AW-1:0] flash_addr_o, // Flash address
	output logic [DW-1:0] flash_dq_o, // Flash data out
	output logic flash_dq_oe_n_o, // Flash data drive, low drives
	input wire logic [DW-1:0] flash_dq_i, // Flash data in
	output logic reset_powerdown_n_o, // Flash reset/power-down, active low
	input wire logic completion_output_i // Completion pin, pulled-up level
);
	import fopc_pkg::*;

	typedef enum logic [3:0] {
		M_IDLE, M_SETUP, M_DATA, M_WAIT, M_POLL, M_ARRAY, M_CLR, M_RST_LO, M_RST_REC
	} fopc_st_e;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_bus_state(input fopc_st_e s);
		return (s == M_SETUP) || (s == M_DATA) || (s == M_POLL) ||
			(s == M_ARRAY) || (s == M_CLR);
	endfunction

	function automatic logic [1:0] decode_result(input logic [7:0] f);
		if (f[FSR_LOCK_DET] && !f[FSR_SUPPLY_ERR] && f[FSR_PROG_ERR]) begin
			return RES_LOCKED;
		end else if (f[FSR_SUPPLY_ERR] && f[FSR_PROG_ERR]) begin
			return RES_SUPPLY;
		end else if (f[FSR_PROG_ERR]) begin
			return RES_PROG_FAIL;
		end
		return RES_OK;
	endfunction

	function automatic logic [DW-1:0] cmd_word(input logic [7:0] c);
		return {{(DW - 8){1'b0}}, c};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fopc_st_e st_r;
	logic sent_r;
	logic req_r;
	logic [CNT_W-1:0] cnt_r;
	logic [31:0] addr_r;
	logic [31:0] data_r;
	logic [7:0] fsr_r;
	logic [1:0] result_r;
	logic supply_lock_r;
	logic aborted_r;
	logic array_mode_r;
	logic rst_pend_r;
	logic [IRQ_W-1:0] irq_st_r;
	logic [IRQ_W-1:0] irq_mask_r;

	fopc_bus_if #(.DW(DW), .AW(AW)) bus_if ();

	fopc_bus_eng #(.DW(DW), .AW(AW), .DIV(PHASE_CYC)) u_eng (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.bus(bus_if.eng),
		.cs_o(chip_select_o),
		.oe_n_o(flash_oe_n_o),
		.we_n_o(flash_we_n_o),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_n_o(flash_dq_oe_n_o),
		.dq_i(flash_dq_i)
	);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_ctrl = we_i && (addr_i == REG_CTRL);
	wire wr_addr = we_i && (addr_i == REG_ADDR);
	wire wr_data = we_i && (addr_i == REG_DATA);
	wire wr_mask = we_i && (addr_i == REG_MASK);
	wire rd_irq = re_i && (addr_i == REG_IRQ);
	wire idle = (st_r == M_IDLE);
	wire busy = !idle;
	wire go_prog = wr_ctrl && wdata_i[CTRL_PROG];
	wire go_clr = wr_ctrl && wdata_i[CTRL_CLR];
	wire go_array = wr_ctrl && wdata_i[CTRL_ARRAY];
	wire go_reset = wr_ctrl && wdata_i[CTRL_RESET];
	wire prog_ok = idle && !supply_lock_r; // R5
	wire cmd_refused = (go_prog && !prog_ok) || ((go_clr || go_array) && busy);
	wire take_reset = rst_pend_r && !sent_r && !req_r; // R10
	wire [7:0] poll_fsr = bus_if.rdata[7:0];
	wire poll_ready = poll_fsr[FSR_READY]; // R3
	wire [1:0] poll_res = decode_result(poll_fsr); // R4
	wire poll_done = (st_r == M_POLL) && bus_if.done && poll_ready;
	wire [31:0] stat_word = {18'h0, array_mode_r, aborted_r, supply_lock_r, result_r, busy, fsr_r};

	// ----------------------------------------------------------------
	// Bus request fields
	// ----------------------------------------------------------------
	assign bus_if.req = req_r;
	assign bus_if.wr = (st_r != M_POLL);
	assign bus_if.addr = addr_r[AW-1:0];
	assign bus_if.wdata = (st_r == M_SETUP) ? cmd_word(CMD_PROT_SETUP) : // R1
		(st_r == M_DATA) ? data_r[DW-1:0] :
		(st_r == M_ARRAY) ? cmd_word(CMD_READ_ARRAY) :
		cmd_word(CMD_CLR_STATUS);

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	wire [IRQ_W-1:0] irq_set;
	assign irq_set[IRQ_DONE] = poll_done;
	assign irq_set[IRQ_ERR] = poll_done && (poll_res != RES_OK);
	assign irq_set[IRQ_REFUSED] = cmd_refused;
	assign irq_set[IRQ_ABORTED] = take_reset && (st_r == M_WAIT || st_r == M_POLL);
	// Set wins over read-clear
	wire [IRQ_W-1:0] irq_st_nxt = (rd_irq ? {IRQ_W{1'b0}} : irq_st_r) | irq_set;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_r <= '0;
			data_r <= '0;
			irq_mask_r <= IRQ_MASK_RST;
			irq_st_r <= '0;
			irq_o <= 1'b0;
		end else begin
			if (wr_addr && idle) begin
				addr_r <= wdata_i;
			end
			if (wr_data && idle) begin
				data_r <= wdata_i;
			end
			if (wr_mask) begin
				irq_mask_r <= wdata_i[IRQ_W-1:0];
			end
			irq_st_r <= irq_st_nxt;
			irq_o <= |(irq_st_nxt & irq_mask_r);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (!re_i) begin
			rdata_o <= '0;
		end else begin
			unique case (addr_i)
				REG_ADDR: rdata_o <= addr_r;
				REG_DATA: rdata_o <= data_r;
				REG_STAT: rdata_o <= stat_word;
				REG_IRQ: rdata_o <= {{(32 - IRQ_W){1'b0}}, irq_st_r};
				REG_MASK: rdata_o <= {{(32 - IRQ_W){1'b0}}, irq_mask_r};
				default: rdata_o <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Request pulse: one per bus cycle; M_POLL requests again until ready
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_r <= 1'b0;
			sent_r <= 1'b0;
		end else begin
			req_r <= is_bus_state(st_r) && !sent_r && !req_r && !take_reset;
			if (bus_if.done) begin
				sent_r <= 1'b0;
			end else if (req_r) begin
				sent_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= M_IDLE;
			cnt_r <= '0;
			rst_pend_r <= 1'b0;
			reset_powerdown_n_o <= 1'b1;
			fsr_r <= '0;
			result_r <= RES_OK;
			supply_lock_r <= 1'b0;
			aborted_r <= 1'b0;
			array_mode_r <= 1'b1; // R14
		end else begin
			if (go_reset) begin
				rst_pend_r <= 1'b1;
			end
			if (take_reset) begin
				// Device ignores all other pins while held in reset
				rst_pend_r <= 1'b0;
				reset_powerdown_n_o <= 1'b0; // R17
				cnt_r <= CNT_W'(RST_PULSE - 1);
				if (st_r == M_WAIT || st_r == M_POLL) begin
					aborted_r <= 1'b1; // R11
				end
				st_r <= M_RST_LO;
			end else begin
				unique case (st_r)
					M_IDLE: begin
						if (go_prog && prog_ok) begin
							array_mode_r <= 1'b0;
							st_r <= M_SETUP;
						end else if (go_clr) begin
							st_r <= M_CLR;
						end else if (go_array) begin
							st_r <= M_ARRAY;
						end
					end
					M_SETUP: if (bus_if.done) begin
						st_r <= M_DATA; // R1
					end
					M_DATA: if (bus_if.done) begin
						st_r <= M_WAIT;
					end
					M_WAIT: if (completion_output_i) begin
						// Pin released: device state machine finished
						st_r <= M_POLL; // R8
					end
					M_POLL: if (bus_if.done) begin
						fsr_r <= poll_fsr;
						if (poll_ready) begin
							result_r <= poll_res; // R6
							if (poll_fsr[FSR_SUPPLY_ERR]) begin
								supply_lock_r <= 1'b1; // R5
							end
							st_r <= M_ARRAY; // R7
						end
					end
					M_ARRAY: if (bus_if.done) begin
						array_mode_r <= 1'b1; // R15
						st_r <= M_IDLE;
					end
					M_CLR: if (bus_if.done) begin
						supply_lock_r <= 1'b0; // R5
						result_r <= RES_OK;
						aborted_r <= 1'b0;
						fsr_r <= '0;
						array_mode_r <= 1'b0;
						st_r <= M_IDLE;
					end
					M_RST_LO: begin
						if (cnt_r == '0) begin
							reset_powerdown_n_o <= 1'b1;
							cnt_r <= CNT_W'(RST_RECOV - 1);
							st_r <= M_RST_REC;
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
					M_RST_REC: begin
						if (cnt_r == '0) begin
							// Device status gone, latch back in read-array
							fsr_r <= '0; // R12
							supply_lock_r <= 1'b0;
							array_mode_r <= 1'b1; // R14
							st_r <= M_IDLE;
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
				endcase
			end
		end
	end
endmodule

// file: rtl/fopc_pkg.sv
// Constants for the flash protection-register program controller
package fopc_pkg;

	// ----------------------------------------------------------------
	// Flash command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_CLR_STATUS = 8'h50;

	// ----------------------------------------------------------------
	// Flash status byte bit positions
	// ----------------------------------------------------------------
	localparam int FSR_READY = 7;
	localparam int FSR_PROG_ERR = 4;
	localparam int FSR_SUPPLY_ERR = 3;
	localparam int FSR_LOCK_DET = 1;

	// ----------------------------------------------------------------
	// Software register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;

	// Control register bits (write one to start)
	localparam int CTRL_PROG = 0;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_ARRAY = 2;
	localparam int CTRL_RESET = 3;

	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_REFUSED = 2;
	localparam int IRQ_ABORTED = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

	// Program result codes
	localparam logic [1:0] RES_OK = 2'h0;
	localparam logic [1:0] RES_SUPPLY = 2'h1;
	localparam logic [1:0] RES_PROG_FAIL = 2'h2;
	localparam logic [1:0] RES_LOCKED = 2'h3;

	// Chip-select patterns
	localparam logic [2:0] CS_ON = 3'h0;
	localparam logic [2:0] CS_OFF = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int T_PHASE_NS = 80;
	localparam int T_RST_PULSE_NS = 100;
	localparam int T_RST_RECOV_NS = 210;
	localparam int PHASE_CYC = (T_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_PULSE_CYC = (T_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_RECOV_CYC = (T_RST_RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 16;

endpackage

// file: tb/fopc_ctrl_sva.sv
// Port-level assertions for the flash program controller
`timescale 1ns/100ps
module fopc_ctrl_sva
	import fopc_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 24,
	parameter int RST_PULSE = 13,
	parameter int RST_RECOV = 27
) (
	input wire logic clk_i, // Clock
	input wire logic rstn_i, // Reset
	input wire logic re_i, // Read strobe
	input wire logic [31:0] rdata_o, // Read data
	input wire logic [2:0] chip_select_o, // Selects
	input wire logic flash_oe_n_o, // Output enable
	input wire logic flash_we_n_o, // Write enable
	input wire logic [DW-1:0] flash_dq_o, // Data out
	input wire logic flash_dq_oe_n_o, // Data drive
	input wire logic [DW-1:0] flash_dq_i, // Data in
	input wire logic reset_powerdown_n_o // Flash reset
);
	logic [7:0] low_cnt_r;
	logic [7:0] rec_cnt_r;
	wire [7:0] low_cnt_nxt = reset_powerdown_n_o ? 8'h00 : low_cnt_r + 8'h01;
	wire rec_sat = rec_cnt_r == 8'hFF;
	wire [7:0] rec_cnt_nxt = !reset_powerdown_n_o ? 8'h00 : rec_cnt_r + {7'h00, !rec_sat};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_cnt_r <= 8'h00;
			rec_cnt_r <= 8'hFF;
		end else begin
			low_cnt_r <= low_cnt_nxt;
			rec_cnt_r <= rec_cnt_nxt;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_setup_done;
		$rose(flash_we_n_o) && flash_dq_o[7:0] == CMD_PROT_SETUP;
	endsequence
	sequence s_ready_rd;
		(!flash_oe_n_o && flash_dq_i[FSR_READY]) ##1 flash_oe_n_o;
	endsequence

	AST_WE_SELECTED: assert property (
		!flash_we_n_o |-> chip_select_o == CS_ON && !flash_dq_oe_n_o && reset_powerdown_n_o)
		else $error("write strobe without select or data drive");
	AST_NO_OE_WE: assert property (!(!flash_oe_n_o && !flash_we_n_o))
		else $error("output and write enable low together");
	AST_READ_RELEASES_DQ: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o)
		else $error("data driven during read");
	AST_RDATA_IDLE: assert property (!$past(re_i) |-> rdata_o == 32'h0)
		else $error("read data outside answer cycle");
	AST_RPN_PULSE: assert property ($rose(reset_powerdown_n_o) |-> low_cnt_r == RST_PULSE)
		else $error("flash reset pulse length wrong");
	AST_QUIET_IN_RESET: assert property (
		$fell(reset_powerdown_n_o) |-> (chip_select_o == CS_OFF)[*8])
		else $error("flash selected in reset");
	AST_RECOVERY: assert property (chip_select_o == CS_ON |-> rec_cnt_r >= RST_RECOV)
		else $error("flash access inside recovery");
	AST_SETUP_THEN_DATA: assert property (
		s_setup_done |-> flash_oe_n_o throughout (##[1:60] $fell(flash_we_n_o)))
		else $error("setup not followed by data write");
	AST_READ_ARRAY_AFTER: assert property (
		s_ready_rd |-> ##[1:80] (!flash_we_n_o && flash_dq_o[7:0] == CMD_READ_ARRAY))
		else $error("no read-array write after ready status");
endmodule

bind fopc_ctrl fopc_ctrl_sva #(.DW(DW), .AW(AW), .RST_PULSE(RST_PULSE), .RST_RECOV(RST_RECOV))
	fopc_ctrl_sva_inst (.clk_i, .rstn_i, .re_i, .rdata_o, .chip_select_o, .flash_oe_n_o,
	.flash_we_n_o, .flash_dq_o, .flash_dq_oe_n_o, .flash_dq_i, .reset_powerdown_n_o);

// file: tb/fopc_flash_model.sv
// Behavioural flash partner: status register, command latch, completion pin
`timescale 1ns/100ps
module fopc_flash_model
	import fopc_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 24,
	parameter int BUSY_CYC = 40,
	parameter logic [23:0] PROT_BASE = 24'h000080,
	parameter int PROT_WORDS = 8
) (
	input wire logic clk_i, // Clock
	input wire logic [2:0] chip_select_i, // Chip selects
	input wire logic oe_n_i, // Output enable
	input wire logic we_n_i, // Write enable
	input wire logic [AW-1:0] addr_i, // Address
	input wire logic [DW-1:0] dq_i, // Data in
	input wire logic dq_oe_n_i, // Host drives dq
	output logic [DW-1:0] dq_o, // Data out
	input wire logic reset_powerdown_n_i, // Reset/power-down
	output logic completion_o, // Completion level
	input wire logic supply_low_i, // Supply below lockout
	input wire logic locked_i // Register locked
);
	logic [7:0] sr_r = 8'h80;
	logic setup_r = 1'b0;
	logic stat_mode_r = 1'b0;
	logic we_n_r = 1'b1;
	logic [DW-1:0] last_r = '0;
	int busy_r = 0;
	logic [7:0] n;
	wire sel = chip_select_i == CS_ON;
	wire cmd_wr = we_n_i && !we_n_r && sel && !dq_oe_n_i;
	wire in_space = addr_i >= PROT_BASE && addr_i < PROT_BASE + PROT_WORDS;
	wire rd_on = sel && !oe_n_i && reset_powerdown_n_i;
	wire [DW-1:0] rd_val = stat_mode_r ? {{(DW-8){1'b0}}, sr_r} : {DW{1'b1}};

	// Released bus shows the inverse of the last value
	assign dq_o = rd_on ? rd_val : ~last_r;
	assign completion_o = !reset_powerdown_n_i || busy_r == 0;

	always @(posedge clk_i) begin
		we_n_r <= we_n_i;
		if (rd_on)
			last_r <= dq_o;
		n = sr_r;
		if (!reset_powerdown_n_i) begin
			n = 8'h80;
			setup_r <= 1'b0;
			stat_mode_r <= 1'b0;
			busy_r <= 0;
		end else begin
			if (busy_r == 1)
				n[FSR_READY] = 1'b1;
			if (busy_r > 0)
				busy_r <= busy_r - 1;
			if (cmd_wr && setup_r) begin
				setup_r <= 1'b0;
				if (!n[FSR_SUPPLY_ERR]) begin
					busy_r <= BUSY_CYC;
					n[FSR_READY] = 1'b0;
					if (supply_low_i)
						n[4:3] = 2'b11;
					else if (!in_space)
						n[FSR_PROG_ERR] = 1'b1;
					else if (locked_i)
						n = n | 8'h12;
				end
			end else if (cmd_wr) begin
				setup_r <= dq_i[7:0] == CMD_PROT_SETUP;
				stat_mode_r <= dq_i[7:0] != CMD_READ_ARRAY;
				if (dq_i[7:0] == CMD_CLR_STATUS)
					n = n & 8'hE5;
			end
		end
		sr_r <= n;
	end
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the flash program controller
`timescale 1ns/100ps
module testbench;
	import fopc_pkg::*;
	localparam logic [23:0] PB = 24'h000080;
	localparam int PW = 8;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [31:0] rdata_o, v;
	logic [2:0] chip_select_o;
	logic irq_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_n_o;
	logic reset_powerdown_n_o, completion_output_i;
	logic [23:0] flash_addr_o;
	logic [15:0] flash_dq_o, flash_dq_i;
	logic supply_low = 1'b0;
	logic locked = 1'b0;
	int errors = 0;
	int total_checks = 0;

	fopc_ctrl fopc_ctrl_inst (.clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
		.irq_o, .chip_select_o, .flash_oe_n_o, .flash_we_n_o, .flash_addr_o, .flash_dq_o,
		.flash_dq_oe_n_o, .flash_dq_i, .reset_powerdown_n_o, .completion_output_i);
	fopc_flash_model #(.BUSY_CYC(200), .PROT_BASE(PB), .PROT_WORDS(PW)) fopc_flash_model_inst (
		.clk_i, .chip_select_i(chip_select_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
		.addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_oe_n_i(flash_dq_oe_n_o),
		.dq_o(flash_dq_i), .reset_powerdown_n_i(reset_powerdown_n_o),
		.completion_o(completion_output_i), .supply_low_i(supply_low), .locked_i(locked));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	task automatic print_verdict();
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic wait_irq();
		for (int n = 0; n < 3000 && irq_o !== 1'b1; n++)
			@(posedge clk_i) #1;
		chk({31'h0, irq_o}, 32'h1);
	endtask

	// Poll the busy bit until the sequencer is back in idle
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h100;
		for (int n = 0; n < 300 && s[8] !== 1'b0; n++)
			rd(REG_STAT, s);
		chk(s & 32'h100, 32'h0);
	endtask

	task automatic clear_status();
		wr(REG_CTRL, 32'h2);
		repeat (3) @(posedge clk_i);
		wait_idle();
	endtask

	// One protection program, then status and interrupt checks
	task automatic prog(input logic [23:0] a, input logic [1:0] res, input logic [7:0] sb);
		wr(REG_ADDR, {8'h00, a});
		wr(REG_DATA, 32'h0000A5C3);
		wr(REG_CTRL, 32'h1);
		wait_irq();
		wait_idle();
		rd(REG_STAT, v);
		chk(v & 32'h7FF, {21'h0, res, 1'b0, sb});
		rd(REG_IRQ, v);
		chk(v & 32'h3, {30'h0, res != RES_OK, 1'b1});
		repeat (2) @(posedge clk_i);
		#1 chk({31'h0, irq_o}, 32'h0);
	endtask

	task automatic t_reset_values();
		rd(REG_STAT, v);
		chk(v, 32'h00002000);
		rd(REG_MASK, v);
		chk(v, {28'h0, IRQ_MASK_RST});
		rd(8'h18, v);
		chk(v, 32'h0);
		wr(REG_MASK, 32'hF);
		rd(REG_MASK, v);
		chk(v, 32'hF);
	endtask

	task automatic t_errors_persist();
		prog(PB + 24'(PW), RES_PROG_FAIL, 8'h90);
		prog(PB + 24'h1, RES_PROG_FAIL, 8'h90);
		clear_status();
		prog(PB + 24'h2, RES_OK, 8'h80);
	endtask

	task automatic t_locked();
		@(posedge clk_i);
		locked <= 1'b1;
		prog(PB + 24'h3, RES_LOCKED, 8'h92);
		@(posedge clk_i);
		locked <= 1'b0;
		clear_status();
	endtask

	task automatic t_supply_refuse();
		@(posedge clk_i);
		supply_low <= 1'b1;
		prog(PB, RES_SUPPLY, 8'h98);
		@(posedge clk_i);
		supply_low <= 1'b0;
		rd(REG_STAT, v);
		chk(v & 32'h800, 32'h800);
		wr(REG_MASK, 32'h0);
		wr(REG_CTRL, 32'h1);
		repeat (20) @(posedge clk_i);
		#1 chk({31'h0, irq_o}, 32'h0);
		wr(REG_MASK, 32'h4);
		repeat (3) @(posedge clk_i);
		#1 chk({31'h0, irq_o}, 32'h1);
		rd(REG_IRQ, v);
		chk(v & 32'h4, 32'h4);
		wr(REG_MASK, 32'hF);
		clear_status();
		rd(REG_STAT, v);
		chk(v & 32'h800, 32'h0);
		prog(PB + 24'h5, RES_OK, 8'h80);
	endtask

	task automatic t_abort();
		wr(REG_ADDR, {8'h00, PB});
		wr(REG_CTRL, 32'h1);
		repeat (120) @(posedge clk_i);
		chk({31'h0, completion_output_i}, 32'h0);
		wr(REG_CTRL, 32'h8);
		wait_irq();
		wait_idle();
		rd(REG_STAT, v);
		chk(v & 32'h30FF, 32'h3000);
		rd(REG_IRQ, v);
		chk(v & 32'h8, 32'h8);
		prog(PB + 24'h4, RES_OK, 8'h80);
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset_values();
		prog(PB, RES_OK, 8'h80);
		t_errors_persist();
		t_locked();
		t_supply_refuse();
		t_abort();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		print_verdict();
	end
endmodule
